// ===== dv/chan_source.sv
`timescale 1ns/10ps
`default_nettype none
module chan_source (
   input wire logic pclk,
   output logic symbol_in_valid,
   output logic [2:0] symbol_in
);
   logic [1:0] hist;
   // Quiet start; encoder history of the far side
   initial begin
      symbol_in_valid = 1'b0;
      symbol_in = 3'h0;
      hist = 2'h0;
   end
   // Far encoder restarts together with the decoder
   task automatic restart();
      hist = 2'h0;
   endtask
   // One symbol per call, g0 = 101 and g1 = 111 taps
   task automatic send(input logic b, input logic [2:0] flip);
      @(posedge pclk);
      symbol_in_valid <= 1'b1;
      symbol_in <= {1'b0, b ^ hist[1] ^ hist[0], b ^ hist[1]} ^ flip;
      hist = {hist[0], b};
   endtask
   // Idle lines toggle so a stale symbol never looks valid
   task automatic idle();
      @(posedge pclk);
      symbol_in_valid <= 1'b0;
      symbol_in <= ~symbol_in;
   endtask
endmodule
`default_nettype wire

// ===== dv/viterbi_codec_checker_props.sv
`timescale 1ns/10ps
`default_nettype none
module viterbi_codec_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic symbol_in_valid,
   input wire logic data_out_valid,
   input wire logic encoder_bit_valid,
   input wire logic [2:0] encoded_symbol_out,
   input wire logic encoded_symbol_valid,
   input wire logic encoded_serial_out,
   input wire logic encoded_serial_valid
);
   // Single domain, so clock and reset are given once
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Bus answers at once; only unmapped words err
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   unmapped_err_a: assert property (psel && penable |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004 ||
                                                                    paddr == 12'h008 || paddr == 12'h00C))
      else $error("error flag wrong for address");
   setup_quiet_a: assert property (psel && !penable |-> !pslverr)
      else $error("error flag in setup phase");
   // A decoded bit is always caused by a symbol three edges back
   out_cause_a: assert property (data_out_valid |-> $past(symbol_in_valid, 3))
      else $error("decoded bit without a symbol");
   // Encoder pipeline: symbol two edges on, then g0 and g1 serially
   enc_latency_a: assert property (encoder_bit_valid |-> ##2 encoded_symbol_valid)
      else $error("encoded symbol late");
   enc_cause_a: assert property (encoded_symbol_valid |-> $past(encoder_bit_valid, 2))
      else $error("encoded symbol without input bit");
   serial_burst_a: assert property (encoded_symbol_valid |=> encoded_serial_valid [*2])
      else $error("serial burst too short");
   serial_g0_a: assert property (encoded_symbol_valid |=> encoded_serial_out == $past(encoded_symbol_out[0]))
      else $error("first serial bit is not g0");
   serial_g1_a: assert property (encoded_symbol_valid ##2 1'b1 |-> encoded_serial_out == $past(encoded_symbol_out[1], 2))
      else $error("second serial bit is not g1");
   rate_half_a: assert property (encoded_symbol_valid |-> !encoded_symbol_out[2])
      else $error("third code bit used at rate one half");
endmodule

bind viterbi_conv_codec viterbi_codec_checker chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .symbol_in_valid(symbol_in_valid),
   .data_out_valid(data_out_valid), .encoder_bit_valid(encoder_bit_valid),
   .encoded_symbol_out(encoded_symbol_out), .encoded_symbol_valid(encoded_symbol_valid),
   .encoded_serial_out(encoded_serial_out), .encoded_serial_valid(encoded_serial_valid)
);
`default_nettype wire

// ===== dv/viterbi_conv_codec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module viterbi_conv_codec_tb;
   logic pclk, presetn, psel, penable, pwrite, clear, enc_v, enc_b, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   wire [31:0] prdata;
   wire pready, pslverr, data_out, data_out_valid, sync_status, sym_v, enc_sym_v, ser, ser_v;
   wire [2:0] sym, enc_sym;
   int mismatches = 0, n_tests = 0, cyc = 0, t_in = -1, t_out = -1;
   logic q[$];

   chan_source src (.pclk(pclk), .symbol_in_valid(sym_v), .symbol_in(sym));
   viterbi_conv_codec dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clear(clear), .symbol_in_valid(sym_v), .symbol_in(sym), .data_out(data_out),
      .data_out_valid(data_out_valid), .sync_status(sync_status), .encoder_bit_valid(enc_v),
      .encoder_bit_in(enc_b), .encoded_symbol_out(enc_sym), .encoded_symbol_valid(enc_sym_v),
      .encoded_serial_out(ser), .encoded_serial_valid(ser_v)
   );

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Collects decoded bits; the ceiling cuts a hang short
   always @(posedge pclk) begin
      cyc++;
      if (sym_v === 1'b1 && t_in < 0) t_in = cyc;
      if (data_out_valid === 1'b1) begin
         if (t_out < 0) t_out = cyc;
         q.push_back(data_out);
      end
      if (cyc > 2000) begin
         mismatches++;
         close_out();
      end
   end

   function automatic logic pat(input int i);
      return ((i * 7 + i / 3) % 5) > 1;
   endfunction

   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // Setup, then access held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends once ready is seen; only the bench ceiling ends a wait that never sees it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_regs();
      apb(1'b0, 12'h004, 32'h0, rd, err);
      chk(rd === 32'h00000004 && err === 1'b0, "threshold reset value");
      apb(1'b1, 12'h004, 32'h00000009, rd, err);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      chk(rd[7:0] === 8'h09, "threshold write");
      apb(1'b0, 12'h000, 32'h0, rd, err);
      chk(rd === 32'h0, "control reads zero");
      apb(1'b0, 12'h00C, 32'h0, rd, err);
      chk(rd[15:0] === 16'h0, "count zero after reset");
      apb(1'b0, 12'h010, 32'h0, rd, err);
      chk(err === 1'b1 && rd === 32'h0, "unmapped word");
      apb(1'b1, 12'h004, 32'h00000004, rd, err);
      $display("test regs done");
   endtask

   // Bits spaced so each serial burst completes
   task automatic t_enc();
      logic [1:0] h;
      logic b;
      int n;
      h = 2'h0;
      for (int i = 0; i < 10; i++) begin
         b = pat(i);
         @(posedge pclk);
         enc_v <= 1'b1;
         enc_b <= b;
         @(posedge pclk);
         enc_v <= 1'b0;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (enc_sym_v !== 1'b1 && n < 8);
         chk(enc_sym_v === 1'b1 && enc_sym === {1'b0, b ^ h[1] ^ h[0], b ^ h[1]}, "encoded symbol");
         h = {h[0], b};
      end
      $display("test encoder done");
   endtask

   // Optional aborted stream, restart, then a stream with one channel error
   task automatic t_stream(input logic via_reg, input int pre);
      int bad;
      bad = 0;
      for (int i = 0; i < pre; i++) src.send(~pat(i), 3'h0);
      src.idle();
      if (via_reg) apb(1'b1, 12'h000, 32'h00000001, rd, err);
      else begin
         @(posedge pclk);
         clear <= 1'b1;
         @(posedge pclk);
         clear <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      src.restart();
      q.delete();
      t_in = -1;
      t_out = -1;
      for (int i = 0; i < 230; i++) begin
         if (i == 200) src.idle();
         src.send(pat(i), (i == 40) ? 3'h2 : 3'h0);
      end
      src.idle();
      repeat (12) @(posedge pclk);
      // 155 clocks to the first bit, plus the edge at which the collector sees it
      chk(t_out - t_in == 156, "first output latency");
      // Steps 153 to 229 each yield one bit
      chk(q.size() == 77, "one bit per step");
      foreach (q[k]) if (q[k] !== pat(k)) bad++;
      chk(bad == 0, "decoded bits");
      apb(1'b0, 12'h008, 32'h0, rd, err);
      chk(rd[0] === 1'b1 && sync_status === 1'b1, "in sync on clean data");
      apb(1'b0, 12'h00C, 32'h0, rd, err);
      chk(rd[15:0] === 16'h0, "no normalization on clean data");
      $display("test stream done");
   endtask

   task automatic close_out();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Reset for 12 cycles, then the scenarios in turn
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      clear = 1'b0;
      enc_v = 1'b0;
      enc_b = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_enc();
      t_stream(1'b0, 0);
      t_stream(1'b1, 60);
      close_out();
   end
endmodule
`default_nettype wire

// ===== logic/conv_encoder_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "viterbi_codec_regs.vh"

module conv_encoder_unit (
   input wire pclk,
   input wire presetn,
   input wire clear,
   input wire bit_valid,
   input wire bit_in,
   output reg [2:0] symbol_out,
   output reg symbol_valid,
   output reg serial_out,
   output reg serial_valid
);
   localparam integer K = `VC_K;
   localparam integer N = (`VC_RATE_SEL == 1) ? 3 : 2;
   localparam [12:0] G0F = `VC_POLY_G0;
   localparam [12:0] G1F = `VC_POLY_G1;
   localparam [12:0] G2F = `VC_POLY_G2;
   localparam [K-1:0] G0 = G0F[K-1:0];
   localparam [K-1:0] G1 = G1F[K-1:0];
   localparam [K-1:0] G2 = G2F[K-1:0];
   localparam [1:0] LAST = N[1:0] - 2'h1;

   reg in_v;
   reg in_b;
   reg [K-2:0] sr;
   reg [2:0] hold;
   reg [1:0] phase;
   reg busy;
   wire [K-1:0] win;
   wire [2:0] next_sym;

   // Newest bit at the bottom, oldest stage at the top
   assign win = {sr, in_b};
   // Third adder only at rate 1/3
   assign next_sym = {(N == 3) ? ^(G2 & win) : 1'b0, ^(G1 & win), ^(G0 & win)};

   // Shift register, adders and output serializer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_v <= 1'b0;
         in_b <= 1'b0;
         sr <= {(K-1){1'b0}};
         hold <= 3'h0;
         phase <= 2'h0;
         busy <= 1'b0;
         symbol_out <= 3'h0;
         symbol_valid <= 1'b0;
         serial_out <= 1'b0;
         serial_valid <= 1'b0;
      end else if (clear) begin
         in_v <= 1'b0;
         sr <= {(K-1){1'b0}};
         busy <= 1'b0;
         phase <= 2'h0;
         symbol_valid <= 1'b0;
         serial_valid <= 1'b0;
      end else begin
         in_v <= bit_valid;
         in_b <= bit_in;
         symbol_valid <= in_v;
         serial_valid <= busy;
         serial_out <= hold[phase];
         if (in_v) begin
            sr <= {sr[K-3:0], in_b};
            symbol_out <= next_sym;
            hold <= next_sym;
            phase <= 2'h0;
            busy <= 1'b1;
         end else if (busy && phase == LAST) begin
            busy <= 1'b0;
         end else if (busy) begin
            phase <= phase + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/viterbi_codec_regs.vh
`ifndef VITERBI_CODEC_REGS_VH
`define VITERBI_CODEC_REGS_VH

// Build-time code selection
`define VC_K 3
`define VC_RATE_SEL 0
`define VC_SOFT_SEL 0
`define VC_SOFT_W 1
`define VC_PAR_SEL 1
`define VC_DEPTH_L 35
`define VC_TB_LAT 3
`define VC_POLY_G0 13'h0005
`define VC_POLY_G1 13'h0007
`define VC_POLY_G2 13'h0007

// Metric arithmetic
`define VC_PM_W 10
`define VC_PM_BIAS 10'h040

// Boundary search window, in trellis steps
`define VC_SYNC_WIN 8'h40

// Register byte offsets
`define VC_OFS_CTRL 12'h000
`define VC_OFS_THR 12'h004
`define VC_OFS_STATUS 12'h008
`define VC_OFS_NORMS 12'h00C

// Field positions
`define VC_CTRL_CLEAR_BIT 0
`define VC_STAT_SYNC_BIT 0
`define VC_STAT_TRY_LSB 8

// Reset values
`define VC_THR_RST 8'h04
`define VC_PM_RST 10'h000

`endif

// ===== logic/viterbi_conv_codec.v
`timescale 1ns/10ps
`default_nettype none
`include "viterbi_codec_regs.vh"

// Behaviour
// - Constraint length is a build choice from 3 to 13 for both coders.
// - Rate select 0 gives rate 1/2, 1 gives 1/3 using third polynomial.
// - Decision select 0 is hard, 1 is soft; hard needs sample width 1.
// - Branch metric is Hamming distance when hard, Euclidean-style distance when soft.
// - Serial mode: too many normalizations slide symbol boundary one bit, then retry.
// - Alignment is reached within n boundary slides for rate 1/n.
// - Synchronization state is shown on a one-bit status output.
// - Interface select 1 is parallel symbols, 0 serial with boundary search.
// - One add-compare-select unit per trellis state, all updated together.
// - Each unit adds, keeps best survivor, stores metric, writes decision bit.
// - Trace-back reads stored decisions over a build-time length and yields bits.
// - Minimum path metric is found over a set number of cycles before trace-back.
// - Decision memory grows by the minimum-search cycles to avoid stalling.
// - Decision storage is four blocks of states times depth plus search latency.
// - First output comes 4 depth plus 3 search latency plus 6 after first input.
// - Encoder: K-1 stage shift register, n modulo-2 adders, serializing multiplexer.
// - Stream and encoder inputs are registered; pslverr is decoded combinationally from the APB inputs; single synchronous clock.
// - One decoded bit per trellis step, sustaining full throughput.
module viterbi_conv_codec (
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire clear,
   input wire symbol_in_valid,
   input wire [3*`VC_SOFT_W-1:0] symbol_in,
   output reg data_out,
   output reg data_out_valid,
   output wire sync_status,
   input wire encoder_bit_valid,
   input wire encoder_bit_in,
   output wire [2:0] encoded_symbol_out,
   output wire encoded_symbol_valid,
   output wire encoded_serial_out,
   output wire encoded_serial_valid
);
   // Build-time code shape
   localparam integer K = `VC_K;
   localparam integer SB = K - 1;
   localparam integer NS = 1 << SB;
   localparam integer N = (`VC_RATE_SEL == 1) ? 3 : 2;
   localparam integer SW = (`VC_SOFT_SEL == 1) ? `VC_SOFT_W : 1;
   localparam integer PAR = `VC_PAR_SEL;
   localparam integer L = `VC_DEPTH_L;
   localparam integer T = `VC_TB_LAT;
   localparam integer DEPTH = 4 * (L + T);
   localparam integer PW = `VC_PM_W;
   localparam integer LAT = 4 * L + 3 * T + 6;
   // Input flop and step flop take two of the LAT clocks
   localparam integer PAD = LAT - T - L - 1;
   localparam [12:0] G0F = `VC_POLY_G0;
   localparam [12:0] G1F = `VC_POLY_G1;
   localparam [12:0] G2F = `VC_POLY_G2;
   localparam [K-1:0] G0 = G0F[K-1:0];
   localparam [K-1:0] G1 = G1F[K-1:0];
   localparam [K-1:0] G2 = G2F[K-1:0];
   localparam [PW-1:0] HALF = {1'b1, {(PW-1){1'b0}}};
   localparam [15:0] LAT16 = LAT[15:0] - 16'h0002;
   localparam [1:0] LASTPH = N[1:0] - 2'h1;
   localparam [7:0] WIN = `VC_SYNC_WIN;

   function integer clog2;
      input integer v;
      integer r;
      begin
         r = 0;
         while ((1 << r) < v)
            r = r + 1;
         clog2 = r;
      end
   endfunction

   localparam integer AW = clog2(DEPTH);
   localparam [AW-1:0] LASTCOL = DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};

   // Expected coder output for a K-bit window, newest bit lowest
   function [2:0] enc_bits;
      input [K-1:0] w;
      begin
         enc_bits = {(N == 3) ? ^(G2 & w) : 1'b0, ^(G1 & w), ^(G0 & w)};
      end
   endfunction

   // Distance of received samples to expected bits; width 1 reduces to Hamming
   function [PW-1:0] branch;
      input [3*`VC_SOFT_W-1:0] r;
      input [2:0] e;
      integer i;
      reg [PW-1:0] acc;
      reg [SW-1:0] s;
      begin
         acc = {PW{1'b0}};
         for (i = 0; i < 3; i = i + 1) begin
            s = r[i*SW +: SW];
            if (i < N)
               acc = acc + {{(PW-SW){1'b0}}, (e[i] ? ~s : s)};
         end
         branch = acc;
      end
   endfunction

   // Column index stepped back through the ring
   function [AW-1:0] col_back;
      input [AW-1:0] p;
      input integer d;
      integer x;
      begin
         x = p;
         x = x - d;
         if (x < 0)
            x = x + DEPTH;
         col_back = x[AW-1:0];
      end
   endfunction

   // Registered stream inputs
   reg in_v_q;
   reg [3*`VC_SOFT_W-1:0] in_sym_q;
   reg clear_q;
   reg clr_pulse;
   wire soft_clear;

   // Symbol assembly and boundary search
   reg step;
   reg [3*`VC_SOFT_W-1:0] sym;
   reg [3*`VC_SOFT_W-1:0] ser_buf;
   reg [3*`VC_SOFT_W-1:0] ser_next;
   reg [1:0] ser_phase;
   reg slip_req;
   reg in_sync;
   reg [1:0] tries;
   reg [7:0] win_cnt;
   reg [7:0] norm_win;
   reg [7:0] norm_thr;
   reg [15:0] norm_total;
   wire [8:0] norm_sum;
   wire too_often;

   // Trellis state
   reg [NS*PW-1:0] pm_flat;
   wire [NS*PW-1:0] next_pm;
   wire [NS-1:0] next_dec;
   reg [NS-1:0] dm [0:DEPTH-1];
   reg [AW-1:0] wp;
   reg [PW-1:0] min_pm;
   reg [SB-1:0] best_st;
   wire norm_evt;
   wire [PW-1:0] norm_sub;
   reg [SB-1:0] tb_state [0:T-1];
   reg [AW-1:0] tb_col [0:T-1];
   reg tb_bit;
   reg [PAD-2:0] dly;
   reg [15:0] fill;
   integer j;

   assign soft_clear = clear_q | clr_pulse;

   // Input capture; all stream pins pass a flop first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_v_q <= 1'b0;
         in_sym_q <= {(3*`VC_SOFT_W){1'b0}};
         clear_q <= 1'b0;
      end else begin
         in_v_q <= symbol_in_valid;
         in_sym_q <= symbol_in;
         clear_q <= clear;
      end
   end

   // Place the newest serial sample at the current boundary phase
   always @* begin
      ser_next = ser_buf;
      ser_next[ser_phase*SW +: SW] = in_sym_q[SW-1:0];
   end

   assign norm_sum = {1'b0, norm_win} + {8'h00, norm_evt};
   // Zero threshold disables the search rather than slipping every window
   assign too_often = (norm_thr != 8'h00) && (norm_sum >= {1'b0, norm_thr});

   // Boundary search: slip one sample when normalizations come too often
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step <= 1'b0;
         sym <= {(3*`VC_SOFT_W){1'b0}};
         ser_buf <= {(3*`VC_SOFT_W){1'b0}};
         ser_phase <= 2'h0;
         slip_req <= 1'b0;
         in_sync <= 1'b0;
         tries <= 2'h0;
         win_cnt <= 8'h00;
         norm_win <= 8'h00;
      end else if (soft_clear) begin
         step <= 1'b0;
         ser_phase <= 2'h0;
         slip_req <= 1'b0;
         in_sync <= 1'b0;
         tries <= 2'h0;
         win_cnt <= 8'h00;
         norm_win <= 8'h00;
      end else begin
         step <= 1'b0;
         if (in_v_q) begin
            if (PAR == 1) begin
               sym <= in_sym_q;
               step <= 1'b1;
            end else if (slip_req) begin
               slip_req <= 1'b0;
            end else if (ser_phase == LASTPH) begin
               sym <= ser_next;
               step <= 1'b1;
               ser_phase <= 2'h0;
            end else begin
               ser_buf <= ser_next;
               ser_phase <= ser_phase + 2'h1;
            end
         end
         // Evaluated once per window so one burst of noise cannot slip twice
         if (step) begin
            if (win_cnt == WIN - 8'h01) begin
               win_cnt <= 8'h00;
               norm_win <= 8'h00;
               if (too_often) begin
                  in_sync <= 1'b0;
                  if (PAR == 0)
                     slip_req <= 1'b1;
                  tries <= (tries == LASTPH) ? 2'h0 : tries + 2'h1;
               end else begin
                  in_sync <= 1'b1;
                  tries <= 2'h0;
               end
            end else begin
               win_cnt <= win_cnt + 8'h01;
               norm_win <= norm_sum[8] ? 8'hFF : norm_sum[7:0];
            end
         end
      end
   end

   assign sync_status = in_sync;

   // Smallest metric and its state; pipelined below to model search latency
   always @* begin : min_search
      integer s;
      min_pm = pm_flat[PW-1:0];
      best_st = {SB{1'b0}};
      for (s = 1; s < NS; s = s + 1) begin
         if (pm_flat[s*PW +: PW] < min_pm) begin
            min_pm = pm_flat[s*PW +: PW];
            best_st = s[SB-1:0];
         end
      end
   end

   // Top bit of the smallest metric set: pull every metric down together
   assign norm_evt = step & min_pm[PW-1];
   assign norm_sub = min_pm[PW-1] ? HALF : {PW{1'b0}};

   // One add-compare-select unit per state
   genvar gs;
   generate
      for (gs = 0; gs < NS; gs = gs + 1) begin : acs_unit
         localparam integer P0 = gs / 2;
         localparam integer P1 = P0 + NS / 2;
         localparam integer B = gs % 2;
         localparam integer W0 = P0 * 2 + B;
         localparam integer W1 = P1 * 2 + B;
         wire [PW-1:0] m0;
         wire [PW-1:0] m1;
         wire pick1;
         assign m0 = pm_flat[P0*PW +: PW] + branch(sym, enc_bits(W0[K-1:0]));
         assign m1 = pm_flat[P1*PW +: PW] + branch(sym, enc_bits(W1[K-1:0]));
         // Ties keep the lower predecessor
         assign pick1 = m1 < m0;
         assign next_dec[gs] = pick1;
         assign next_pm[gs*PW +: PW] = (pick1 ? m1 : m0) - norm_sub;
      end
   endgenerate

   // Walk survivors back from the delayed best state
   always @* begin : tb_walk
      integer i;
      reg [SB-1:0] st;
      reg [AW-1:0] col;
      st = tb_state[T-1];
      col = tb_col[T-1];
      tb_bit = 1'b0;
      for (i = 0; i < L; i = i + 1) begin
         tb_bit = st[0];
         st = {dm[col][st], st[SB-1:1]};
         col = col_back(col, 1);
      end
   end

   // Decision ring; data only, so it carries no reset
   always @(posedge pclk) begin
      if (step)
         dm[wp] <= next_dec;
   end

   // Metrics, pointers and output path; one trellis step per accepted symbol
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_flat <= {NS{`VC_PM_RST}};
         wp <= {AW{1'b0}};
         dly <= {(PAD-1){1'b0}};
         fill <= 16'h0000;
         data_out <= 1'b0;
         data_out_valid <= 1'b0;
         for (j = 0; j < T; j = j + 1) begin
            tb_state[j] <= {SB{1'b0}};
            tb_col[j] <= {AW{1'b0}};
         end
      end else if (soft_clear) begin
         // Start from the all-zero coder state
         pm_flat <= {{(NS-1){`VC_PM_BIAS}}, `VC_PM_RST};
         wp <= {AW{1'b0}};
         fill <= 16'h0000;
         data_out_valid <= 1'b0;
      end else begin
         data_out_valid <= 1'b0;
         if (step) begin
            pm_flat <= next_pm;
            wp <= (wp == LASTCOL) ? {AW{1'b0}} : wp + {{(AW-1){1'b0}}, 1'b1};
            tb_state[0] <= best_st;
            tb_col[0] <= col_back(wp, 1);
            for (j = 1; j < T; j = j + 1) begin
               tb_state[j] <= tb_state[j-1];
               tb_col[j] <= tb_col[j-1];
            end
            dly <= {dly[PAD-3:0], tb_bit};
            data_out <= dly[PAD-2];
            data_out_valid <= (fill >= LAT16);
            if (fill != 16'hFFFF)
               fill <= fill + 16'h0001;
         end
      end
   end

   // APB slave; zero wait states, unmapped offsets answer with an error
   wire apb_wr;
   wire mapped;

   assign pready = 1'b1;
   assign mapped = (paddr == `VC_OFS_CTRL) || (paddr == `VC_OFS_THR) ||
                   (paddr == `VC_OFS_STATUS) || (paddr == `VC_OFS_NORMS);
   assign pslverr = psel & penable & ~mapped;
   assign apb_wr = psel & penable & pwrite & mapped;

   // Control writes; clear bit is a self-clearing pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_pulse <= 1'b0;
         norm_thr <= `VC_THR_RST;
         norm_total <= 16'h0000;
      end else begin
         clr_pulse <= apb_wr && (paddr == `VC_OFS_CTRL) && pwdata[`VC_CTRL_CLEAR_BIT];
         if (apb_wr && paddr == `VC_OFS_THR)
            norm_thr <= pwdata[7:0];
         // Wraps; software takes differences
         if (norm_evt)
            norm_total <= norm_total + 16'h0001;
      end
   end

   // Read data latched in the setup phase, stable through the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `VC_OFS_THR: prdata <= {24'h000000, norm_thr};
            `VC_OFS_STATUS: begin
               prdata <= 32'h00000000;
               prdata[`VC_STAT_SYNC_BIT] <= in_sync;
               prdata[`VC_STAT_TRY_LSB +: 2] <= tries;
            end
            `VC_OFS_NORMS: prdata <= {16'h0000, norm_total};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // Encoder shares the clock and the clear
   conv_encoder_unit u_encoder (
      .pclk(pclk),
      .presetn(presetn),
      .clear(soft_clear),
      .bit_valid(encoder_bit_valid),
      .bit_in(encoder_bit_in),
      .symbol_out(encoded_symbol_out),
      .symbol_valid(encoded_symbol_valid),
      .serial_out(encoded_serial_out),
      .serial_valid(encoded_serial_valid)
   );
endmodule
`default_nettype wire
